// *** src/hsp_pkg.sv ***
// Behaviour
// - after reset all keypad column pins are full-buffer with pull-up on.
// - after reset all keypad row pins are full-buffer with pull-down on.
// - power-on reset sets the power-on flag and pulls attention low.
// - the power-on flag, and its pull on attention, is cleared only by writing 0x01 to register 0x84.
// - after reset clock and data pins are open-drain without pulls.
// - in halt the internal oscillator is stopped.
// - halt is entered after the inactivity period, 1020 ms by default.
// - halt entry is always on; host may reprogram the period.
// - in halt only traffic with our own address wakes the device.
// - the address that wakes the device is answered with a not-acknowledge.
// - traffic for other devices neither restarts the timer nor wakes us.
// - host makes start and stop; 7-bit address compared with our own.
// - direction bit 0 is a host write, 1 is a read from the device.
// - each byte is followed by one acknowledge bit from the receiver.
// - first byte written after the address is the register pointer.
// - host ends a read with not-acknowledge; device then frees data line.
// - attention is pulled low while the power-on flag or an enabled interrupt is pending; key events do not pull it.
// - pointer increments by one after each data byte, kept across stop until the next pointer byte.
// - single-byte write of 0x06 to general-call address 0x00 is a reset.
// - general-call reset restores the slave address to 0x88.
// - device may stretch the clock; host waits until it is released.
package hsp_pkg;

  localparam logic [7:0] RESET_CLEAR_REG = 8'h84;
  localparam logic [7:0] RESET_CLEAR_VAL = 8'h01;
  localparam logic [7:0] SLAVE_ADDR_REG = 8'h80;
  localparam logic [7:0] SLEEP_PERIOD_REG = 8'h8b;
  localparam logic [7:0] SLAVE_ADDR_RST = 8'h88;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] GC_RESET_CMD = 8'h06;

  localparam logic [7:0] COL_PULL_UP_RST = 8'hff;
  localparam logic [11:0] ROW_PULL_DOWN_RST = 12'hfff;

  localparam int CLK_HZ = 40_000_000;
  localparam int SLEEP_UNIT_MS = 4;
  localparam int SLEEP_DEFAULT_MS = 1020;
  localparam int SLEEP_TICK_CYCLES = (CLK_HZ / 1000) * SLEEP_UNIT_MS;
  localparam logic [7:0] SLEEP_PERIOD_RST = 8'(SLEEP_DEFAULT_MS / SLEEP_UNIT_MS);
  localparam int PRESCALE_W = 18;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;

  typedef enum logic [2:0] {
    LS_IDLE  = 3'b000,
    LS_ADDR  = 3'b001,
    LS_AACK  = 3'b011,
    LS_RXB   = 3'b010,
    LS_RACK  = 3'b110,
    LS_FETCH = 3'b111,
    LS_TXB   = 3'b101,
    LS_TACK  = 3'b100
  } link_state_t;

endpackage

// *** src/bit_sync.sv ***
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk, // destination clock
  input wire logic sys_rst, // async reset, active high
  input wire logic [W-1:0] d, // foreign-domain levels
  output logic [W-1:0] q // synchronised levels
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= INIT;
      q <= INIT;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // bit_sync

// *** src/sleep_timer.sv ***
`timescale 1ns/1ps
module sleep_timer #(
  parameter int TICK_CYCLES = hsp_pkg::SLEEP_TICK_CYCLES
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic restart, // qualifying activity pulse
  input wire logic wake, // addressed wake-up pulse
  input wire logic [7:0] period, // inactivity period in units
  output logic halted_r // halt mode
);
  logic [hsp_pkg::PRESCALE_W-1:0] pre_r;
  logic [7:0] unit_r;
  logic tick;
  logic [7:0] limit;

  assign tick = (pre_r == hsp_pkg::PRESCALE_W'(TICK_CYCLES - 1));
  // zero period would halt at once; treat as one unit
  assign limit = (period == 8'h00) ? 8'h01 : period;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_r <= '0;
    end else if (restart || wake || halted_r || tick) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      unit_r <= 8'h00;
    end else if (restart || wake || halted_r) begin
      unit_r <= 8'h00;
    end else if (tick) begin
      unit_r <= unit_r + 8'h01;
    end
  end

  // entry cannot be disabled; activity in the expiry cycle wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      halted_r <= 1'b0;
    end else if (wake) begin
      halted_r <= 1'b0;
    end else if (!halted_r && !restart && tick && (unit_r + 8'h01 >= limit)) begin
      halted_r <= 1'b1;
    end
  end
endmodule // sleep_timer

// *** src/host_serial_port_with_sleep.sv ***
`timescale 1ns/1ps
module host_serial_port_with_sleep #(
  parameter int SLEEP_TICK_CYCLES = hsp_pkg::SLEEP_TICK_CYCLES
) (
  input wire logic clk, // system clock, 40 MHz
  input wire logic link_clk, // bus sampling clock
  input wire logic sys_rst, // async reset, active high
  input wire logic scl_in, // serial clock pin level
  output logic scl_out, // serial clock value
  output logic scl_oe_n, // serial clock enable, low drives
  input wire logic sda_in, // serial data pin level
  output logic sda_out, // serial data value
  output logic sda_oe_n, // serial data enable, low drives
  output logic host_attention_out, // attention drive value
  output logic host_attention_oe_n, // attention enable, low pulls
  input wire logic irq_request, // enabled interrupt pending
  input wire logic key_press, // key press pulse
  input wire logic key_release, // key release pulse
  output logic [7:0] reg_addr, // register pointer to core
  output logic [7:0] reg_wdata, // register write data
  output logic reg_wr, // register write pulse
  output logic reg_rd, // register read pulse
  input wire logic [7:0] reg_rdata, // read data for reg_addr
  output logic power_on_event_flag, // power-on event pending
  output logic osc_run, // oscillator enable
  output logic keypad_pins_full_buffer, // full-buffer mode
  output logic [7:0] keypad_column_pins_pull_up, // column pull-ups
  output logic [11:0] keypad_row_pins_pull_down // row pull-downs
);
  // ---------------- link domain ----------------
  logic scl_s, sda_s, rd_ack_s, halt_s;
  logic halted_w;
  logic rd_ack_t_r;
  logic [7:0] rd_data_r;
  logic scl_d_r, sda_d_r;
  hsp_pkg::link_state_t st_r;
  logic [7:0] sh_r;
  logic [3:0] cnt_r;
  logic rw_r, gc_r, first_r, nack_r;
  logic [7:0] ptr_r, own_addr_r;
  logic sda_oe_n_r, scl_oe_n_r;
  logic wr_t_r, rd_t_r, act_t_r, wake_t_r;
  logic [7:0] wptr_r, wdata_r, rptr_r;

  bit_sync #(.W(4), .INIT(4'h3)) link_sync (
    .clk(link_clk),
    .sys_rst(sys_rst),
    .d({halted_w, rd_ack_t_r, sda_in, scl_in}),
    .q({halt_s, rd_ack_s, sda_s, scl_s})
  );

  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  logic scl_rise, scl_fall, start_c, stop_c;
  logic a_own, a_gc, addr_end, addr_ack, addr_wake;
  logic rx_end, rx_ptr, rx_data, gc_cmd, tx_end, enter_fetch, ready;

  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign start_c = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_c = scl_s && scl_d_r && !sda_d_r && sda_s;
  assign a_own = (sh_r[7:1] == own_addr_r[7:1]);
  assign a_gc = (sh_r == hsp_pkg::GC_ADDR);
  assign addr_end = (st_r == hsp_pkg::LS_ADDR) && scl_fall && (cnt_r == hsp_pkg::BITS_PER_BYTE);
  assign addr_ack = addr_end && ((a_own && !halt_s) || a_gc);
  assign addr_wake = addr_end && a_own && halt_s;
  assign rx_end = (st_r == hsp_pkg::LS_RXB) && scl_fall && (cnt_r == hsp_pkg::BITS_PER_BYTE);
  assign rx_ptr = rx_end && first_r && !gc_r;
  assign rx_data = rx_end && !first_r && !gc_r;
  assign gc_cmd = rx_end && gc_r && (sh_r == hsp_pkg::GC_RESET_CMD);
  assign tx_end = (st_r == hsp_pkg::LS_TXB) && scl_fall && (cnt_r == hsp_pkg::LAST_TX_BIT);
  assign enter_fetch = scl_fall && (((st_r == hsp_pkg::LS_AACK) && rw_r) ||
                                    ((st_r == hsp_pkg::LS_TACK) && !nack_r));
  assign ready = (rd_ack_s == rd_t_r);

  // protocol engine: state, shifter, bit count, data line
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= hsp_pkg::LS_IDLE;
      sh_r <= 8'h00;
      cnt_r <= 4'h0;
      rw_r <= 1'b0;
      gc_r <= 1'b0;
      first_r <= 1'b0;
      nack_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
    end else if (start_c) begin
      st_r <= hsp_pkg::LS_ADDR;
      cnt_r <= 4'h0;
      sda_oe_n_r <= 1'b1;
    end else if (stop_c) begin
      st_r <= hsp_pkg::LS_IDLE;
      sda_oe_n_r <= 1'b1;
    end else begin
      unique case (st_r)
        hsp_pkg::LS_IDLE: begin
        end
        hsp_pkg::LS_ADDR: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end else if (addr_end) begin
            if (addr_ack) begin
              sda_oe_n_r <= 1'b0;
              rw_r <= sh_r[0];
              gc_r <= a_gc;
              first_r <= !sh_r[0];
              st_r <= hsp_pkg::LS_AACK;
            end else begin
              st_r <= hsp_pkg::LS_IDLE;
            end
          end
        end
        hsp_pkg::LS_AACK: begin
          if (scl_fall) begin
            sda_oe_n_r <= 1'b1;
            cnt_r <= 4'h0;
            st_r <= rw_r ? hsp_pkg::LS_FETCH : hsp_pkg::LS_RXB;
          end
        end
        hsp_pkg::LS_RXB: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end else if (rx_end) begin
            sda_oe_n_r <= 1'b0;
            first_r <= 1'b0;
            st_r <= hsp_pkg::LS_RACK;
          end
        end
        hsp_pkg::LS_RACK: begin
          if (scl_fall) begin
            sda_oe_n_r <= 1'b1;
            cnt_r <= 4'h0;
            st_r <= hsp_pkg::LS_RXB;
          end
        end
        hsp_pkg::LS_FETCH: begin
          if (ready) begin
            sh_r <= rd_data_r;
            sda_oe_n_r <= rd_data_r[7];
            cnt_r <= 4'h0;
            st_r <= hsp_pkg::LS_TXB;
          end
        end
        hsp_pkg::LS_TXB: begin
          if (tx_end) begin
            sda_oe_n_r <= 1'b1;
            st_r <= hsp_pkg::LS_TACK;
          end else if (scl_fall) begin
            sh_r <= {sh_r[6:0], 1'b0};
            sda_oe_n_r <= sh_r[6];
            cnt_r <= cnt_r + 4'h1;
          end
        end
        hsp_pkg::LS_TACK: begin
          if (scl_rise) begin
            nack_r <= sda_s;
          end else if (scl_fall) begin
            st_r <= nack_r ? hsp_pkg::LS_IDLE : hsp_pkg::LS_FETCH;
          end
        end
      endcase
    end
  end

  // stretch while read data crosses
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_oe_n_r <= 1'b1;
    end else begin
      scl_oe_n_r <= !(enter_fetch || ((st_r == hsp_pkg::LS_FETCH) && !ready));
    end
  end

  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_r <= 8'h00;
    end else if (rx_ptr) begin
      ptr_r <= sh_r;
    end else if (rx_data || tx_end) begin
      ptr_r <= ptr_r + 8'h01;
    end
  end

  // address lives here so the comparator needs no crossing
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      own_addr_r <= hsp_pkg::SLAVE_ADDR_RST;
    end else if (gc_cmd) begin
      own_addr_r <= hsp_pkg::SLAVE_ADDR_RST;
    end else if (rx_data && (ptr_r == hsp_pkg::SLAVE_ADDR_REG)) begin
      own_addr_r <= sh_r;
    end
  end

  // events cross as toggles beside held words
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_t_r <= 1'b0;
      rd_t_r <= 1'b0;
      act_t_r <= 1'b0;
      wake_t_r <= 1'b0;
      wptr_r <= 8'h00;
      wdata_r <= 8'h00;
      rptr_r <= 8'h00;
    end else begin
      if (rx_data) begin
        wr_t_r <= !wr_t_r;
        wptr_r <= ptr_r;
        wdata_r <= sh_r;
      end
      if (enter_fetch) begin
        rd_t_r <= !rd_t_r;
        rptr_r <= ptr_r;
      end
      if (addr_ack || rx_end || enter_fetch) begin
        act_t_r <= !act_t_r;
      end
      if (addr_wake) begin
        wake_t_r <= !wake_t_r;
      end
    end
  end

  // ---------------- system domain ----------------
  logic wr_s, rd_s, act_s, wake_s;
  logic [3:0] ev_d_r;
  logic wr_ev, rd_ev, act_ev, wake_ev;
  logic internal_wr;
  logic power_on_r;
  logic [7:0] sleep_period_r;
  logic rd_pend_r;
  logic [7:0] reg_addr_r, reg_wdata_r;
  logic reg_wr_r, reg_rd_r;
  logic osc_run_r, attn_oe_n_r, od_zero_r;

  bit_sync #(.W(4), .INIT(4'h0)) sys_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({wake_t_r, act_t_r, rd_t_r, wr_t_r}),
    .q({wake_s, act_s, rd_s, wr_s})
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ev_d_r <= 4'h0;
    end else begin
      ev_d_r <= {wake_s, act_s, rd_s, wr_s};
    end
  end

  assign wr_ev = wr_s ^ ev_d_r[0];
  assign rd_ev = rd_s ^ ev_d_r[1];
  assign act_ev = act_s ^ ev_d_r[2];
  assign wake_ev = wake_s ^ ev_d_r[3];
  assign internal_wr = (wptr_r == hsp_pkg::RESET_CLEAR_REG) ||
                       (wptr_r == hsp_pkg::SLEEP_PERIOD_REG) ||
                       (wptr_r == hsp_pkg::SLAVE_ADDR_REG);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      power_on_r <= 1'b1;
    end else if (wr_ev && (wptr_r == hsp_pkg::RESET_CLEAR_REG) &&
                 (wdata_r == hsp_pkg::RESET_CLEAR_VAL)) begin
      power_on_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_period_r <= hsp_pkg::SLEEP_PERIOD_RST;
    end else if (wr_ev && (wptr_r == hsp_pkg::SLEEP_PERIOD_REG)) begin
      sleep_period_r <= wdata_r;
    end
  end

  // core strobes; read data taken a cycle after the address
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_addr_r <= 8'h00;
      reg_wdata_r <= 8'h00;
      reg_wr_r <= 1'b0;
      reg_rd_r <= 1'b0;
      rd_pend_r <= 1'b0;
      rd_data_r <= 8'h00;
      rd_ack_t_r <= 1'b0;
    end else begin
      reg_wr_r <= wr_ev && !internal_wr;
      reg_rd_r <= rd_ev;
      rd_pend_r <= rd_ev;
      if (wr_ev) begin
        reg_addr_r <= wptr_r;
        reg_wdata_r <= wdata_r;
      end else if (rd_ev) begin
        reg_addr_r <= rptr_r;
      end
      if (rd_pend_r) begin
        rd_data_r <= (reg_addr_r == hsp_pkg::SLEEP_PERIOD_REG) ? sleep_period_r : reg_rdata;
        rd_ack_t_r <= !rd_ack_t_r;
      end
    end
  end

  sleep_timer #(.TICK_CYCLES(SLEEP_TICK_CYCLES)) halt_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .restart(act_ev || key_press || key_release),
    .wake(wake_ev),
    .period(sleep_period_r),
    .halted_r(halted_w)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_run_r <= 1'b1;
    end else begin
      osc_run_r <= !halted_w;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      attn_oe_n_r <= 1'b0;
    end else begin
      attn_oe_n_r <= !(power_on_r || irq_request);
    end
  end

  // open-drain pads only ever pull low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      od_zero_r <= 1'b0;
    end else begin
      od_zero_r <= 1'b0;
    end
  end

  logic full_buf_r;
  logic [7:0] col_pu_r;
  logic [11:0] row_pd_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      full_buf_r <= 1'b1;
      col_pu_r <= hsp_pkg::COL_PULL_UP_RST;
      row_pd_r <= hsp_pkg::ROW_PULL_DOWN_RST;
    end else begin
      full_buf_r <= full_buf_r;
      col_pu_r <= col_pu_r;
      row_pd_r <= row_pd_r;
    end
  end

  assign scl_out = od_zero_r;
  assign scl_oe_n = scl_oe_n_r;
  assign sda_out = od_zero_r;
  assign sda_oe_n = sda_oe_n_r;
  assign host_attention_out = od_zero_r;
  assign host_attention_oe_n = attn_oe_n_r;
  assign reg_addr = reg_addr_r;
  assign reg_wdata = reg_wdata_r;
  assign reg_wr = reg_wr_r;
  assign reg_rd = reg_rd_r;
  assign power_on_event_flag = power_on_r;
  assign osc_run = osc_run_r;
  assign keypad_pins_full_buffer = full_buf_r;
  assign keypad_column_pins_pull_up = col_pu_r;
  assign keypad_row_pins_pull_down = row_pd_r;
endmodule // host_serial_port_with_sleep

// *** testbench/hsp_checker_sva.sv ***
`timescale 1ns/1ps
module hsp_checker (
  input wire logic clk, // system clock
  input wire logic link_clk, // link clock
  input wire logic sys_rst, // async reset
  input wire logic scl_in, // clock pin level
  input wire logic scl_out, // clock value
  input wire logic scl_oe_n, // clock enable
  input wire logic sda_out, // data value
  input wire logic sda_oe_n, // data enable
  input wire logic host_attention_out, // attention value
  input wire logic host_attention_oe_n, // attention enable
  input wire logic irq_request, // interrupt pending
  input wire logic key_press, // key press pulse
  input wire logic key_release, // key release pulse
  input wire logic reg_wr, // write pulse
  input wire logic reg_rd, // read pulse
  input wire logic power_on_event_flag, // power-on flag
  input wire logic osc_run, // oscillator enable
  input wire logic keypad_pins_full_buffer, // full-buffer mode
  input wire logic [7:0] keypad_column_pins_pull_up, // column pull-ups
  input wire logic [11:0] keypad_row_pins_pull_down // row pull-downs
);
  sequence released_8;
    sda_oe_n [*8];
  endsequence
  sequence stretch_end;
    ##[1:16] scl_oe_n;
  endsequence
  col_pull_a: assert property (@(posedge clk) disable iff (sys_rst)
    keypad_pins_full_buffer && keypad_column_pins_pull_up == 8'hff)
    else $error("column setup lost");
  row_pull_a: assert property (@(posedge clk) disable iff (sys_rst)
    keypad_row_pins_pull_down == 12'hfff)
    else $error("row setup lost");
  open_drain_a: assert property (@(posedge clk) disable iff (sys_rst)
    !scl_out && !sda_out && !host_attention_out)
    else $error("open-drain high");
  attn_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    (power_on_event_flag || irq_request) |=> !host_attention_oe_n)
    else $error("attention not pulled low");
  attn_release_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!power_on_event_flag && !irq_request) |=> host_attention_oe_n)
    else $error("attention not released");
  flag_sticky_a: assert property (@(posedge clk) disable iff (sys_rst)
    !$rose(power_on_event_flag))
    else $error("flag set after reset");
  halt_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
    !osc_run |-> !reg_wr && !reg_rd)
    else $error("access while halted");
  key_nowake_a: assert property (@(posedge clk) disable iff (sys_rst)
    !osc_run && (key_press || key_release) |=> !osc_run)
    else $error("key event woke the device");
  key_restart_a: assert property (@(posedge clk) disable iff (sys_rst)
    osc_run && key_press |=> osc_run [*8])
    else $error("halt after key");
  wake_nack_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(osc_run) |-> released_8)
    else $error("wake address acked");
  sda_in_low_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    $fell(sda_oe_n) |-> !scl_in)
    else $error("sda pulled, scl high");
  stretch_low_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    $fell(scl_oe_n) |-> !scl_in)
    else $error("stretch at scl high");
  stretch_bound_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    !scl_oe_n |-> stretch_end)
    else $error("stretch too long");
endmodule // hsp_checker

bind host_serial_port_with_sleep hsp_checker u_chk (
  .clk(clk), .link_clk(link_clk), .sys_rst(sys_rst), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .host_attention_out(host_attention_out), .host_attention_oe_n(host_attention_oe_n),
  .irq_request(irq_request), .key_press(key_press), .key_release(key_release),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .power_on_event_flag(power_on_event_flag),
  .osc_run(osc_run), .keypad_pins_full_buffer(keypad_pins_full_buffer),
  .keypad_column_pins_pull_up(keypad_column_pins_pull_up),
  .keypad_row_pins_pull_down(keypad_row_pins_pull_down));

// *** testbench/i2c_host_model.sv ***
`timescale 1ns/1ps
module i2c_host_model #(
  parameter int HALF = 6
) (
  input wire logic link_clk, // pacing clock
  input wire logic scl_wire, // resolved clock line
  input wire logic sda_wire, // resolved data line
  output logic scl_drv, // 0 pulls clock low
  output logic sda_drv, // 0 pulls data low
  output logic hung // clock never released
);
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
    hung = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
  endtask
  // bounded so a stuck stretch cannot hang the run
  task automatic scl_up();
    scl_drv <= 1'b1;
    tick(1);
    for (int i = 0; i < 200 && scl_wire !== 1'b1; i++) tick(1);
    if (scl_wire !== 1'b1) hung <= 1'b1;
  endtask
  task automatic start();
    sda_drv <= 1'b1;
    tick(HALF);
    scl_up();
    tick(HALF);
    sda_drv <= 1'b0;
    tick(HALF);
    scl_drv <= 1'b0;
    tick(HALF);
  endtask
  task automatic stop();
    sda_drv <= 1'b0;
    tick(HALF);
    scl_up();
    tick(HALF);
    sda_drv <= 1'b1;
    tick(HALF);
  endtask
  task automatic clock_bit(input logic b, output logic seen);
    sda_drv <= b;
    tick(HALF);
    scl_up();
    tick(HALF / 2);
    seen = sda_wire;
    tick(HALF - HALF / 2);
    scl_drv <= 1'b0;
    tick(1);
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(d[i], s);
    clock_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, s);
      d[i] = s;
    end
    clock_bit(last, s);
  endtask
endmodule // i2c_host_model

// *** testbench/tb_host_serial_port_with_sleep.sv ***
`timescale 1ns/1ps
module tb_host_serial_port_with_sleep;
  localparam int TICK = 20;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic irq_request = 1'b0;
  logic key_press = 1'b0;
  logic key_release = 1'b0;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, host_attention_out, host_attention_oe_n;
  logic reg_wr, reg_rd, power_on_event_flag, osc_run, keypad_pins_full_buffer;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, keypad_column_pins_pull_up;
  logic [11:0] keypad_row_pins_pull_down;
  logic scl_drv, sda_drv, hung;
  wire scl_line = scl_drv & (scl_oe_n | scl_out);
  wire sda_line = sda_drv & (sda_oe_n | sda_out);
  logic [15:0] wr_q[$];
  int num_errors = 0;
  int num_checks = 0;
  always #12.5 clk = ~clk;
  always #80 link_clk = ~link_clk;
  // core stand-in: data follows the pointer
  assign reg_rdata = reg_addr ^ 8'h5a;
  always @(posedge clk) if (reg_wr === 1'b1) wr_q.push_back({reg_addr, reg_wdata});
  host_serial_port_with_sleep #(.SLEEP_TICK_CYCLES(TICK)) u_dut (
    .clk(clk), .link_clk(link_clk), .sys_rst(sys_rst), .scl_in(scl_line), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .host_attention_out(host_attention_out), .host_attention_oe_n(host_attention_oe_n),
    .irq_request(irq_request), .key_press(key_press), .key_release(key_release),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .power_on_event_flag(power_on_event_flag), .osc_run(osc_run),
    .keypad_pins_full_buffer(keypad_pins_full_buffer),
    .keypad_column_pins_pull_up(keypad_column_pins_pull_up),
    .keypad_row_pins_pull_down(keypad_row_pins_pull_down));
  i2c_host_model u_host (.link_clk(link_clk), .scl_wire(scl_line), .sda_wire(sda_line),
    .scl_drv(scl_drv), .sda_drv(sda_drv), .hung(hung));
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic probe(input logic [7:0] dev, output logic ack);
    u_host.start();
    u_host.send_byte(dev, ack);
    u_host.stop();
  endtask
  task automatic reg_write(input logic [7:0] dev, ptr, dat, output logic [2:0] acks);
    u_host.start();
    u_host.send_byte(dev, acks[2]);
    u_host.send_byte(ptr, acks[1]);
    u_host.send_byte(dat, acks[0]);
    u_host.stop();
  endtask
  task automatic halt_after(input int units, input logic rel);
    int n = 0;
    @(posedge clk);
    key_press <= !rel;
    key_release <= rel;
    @(posedge clk);
    key_press <= 1'b0;
    key_release <= 1'b0;
    while (osc_run !== 1'b0 && n < 6000) begin
      @(negedge clk);
      n++;
    end
    check("halt_early", n >= (units - 1) * TICK, 1'b1);
    check("halt_late", n <= units * TICK + 8, 1'b1);
  endtask
  task automatic t_reset();
    check("col_pull", keypad_column_pins_pull_up, 8'hff);
    check("row_pull", keypad_row_pins_pull_down, 12'hfff);
    check("full_buf", keypad_pins_full_buffer, 1'b1);
    check("attn_oe_n", host_attention_oe_n, 1'b0);
    check("por_flag", power_on_event_flag, 1'b1);
    check("bus_oe_n", {scl_oe_n, sda_oe_n}, 2'b11);
  endtask
  task automatic t_write();
    logic [3:0] a;
    wr_q.delete();
    u_host.start();
    u_host.send_byte(8'h88, a[3]);
    u_host.send_byte(8'haa, a[2]);
    u_host.send_byte(8'h01, a[1]);
    u_host.send_byte(8'h05, a[0]);
    u_host.stop();
    check("wr_acks", a, 4'hf);
    check("wr_count", 16'(wr_q.size()), 16'd2);
    check("wr_first", wr_q[0], 16'haa01);
    check("wr_second", wr_q[1], 16'hab05);
  endtask
  task automatic t_read();
    logic [2:0] a;
    logic [7:0] d0, d1;
    u_host.start();
    u_host.send_byte(8'h88, a[2]);
    u_host.send_byte(8'h30, a[1]);
    u_host.start();
    u_host.send_byte(8'h89, a[0]);
    u_host.recv_byte(1'b0, d0);
    u_host.recv_byte(1'b1, d1);
    u_host.tick(8);
    check("rd_release", sda_oe_n, 1'b1);
    u_host.stop();
    check("rd_acks", a, 3'b111);
    check("rd_first", d0, 8'h30 ^ 8'h5a);
    check("rd_second", d1, 8'h31 ^ 8'h5a);
  endtask
  task automatic t_attention();
    logic [2:0] a;
    wr_q.delete();
    reg_write(8'h88, hsp_pkg::RESET_CLEAR_REG, 8'h02, a);
    check("flag_kept", {power_on_event_flag, host_attention_oe_n}, 2'b10);
    reg_write(8'h88, hsp_pkg::RESET_CLEAR_REG, hsp_pkg::RESET_CLEAR_VAL, a);
    check("flag_clear", {power_on_event_flag, host_attention_oe_n}, 2'b01);
    check("clr_no_wr", 16'(wr_q.size()), 16'd0);
    @(posedge clk);
    irq_request <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check("irq_attn", host_attention_oe_n, 1'b0);
    @(posedge clk);
    irq_request <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check("irq_gone", host_attention_oe_n, 1'b1);
  endtask
  task automatic t_foreign_and_gc();
    logic a;
    logic [2:0] w;
    wr_q.delete();
    probe(8'h50, a);
    check("foreign_ack", {a, 8'(wr_q.size())}, 9'd0);
    reg_write(8'h88, hsp_pkg::SLAVE_ADDR_REG, 8'h20, w);
    check("addr_set", w, 3'b111);
    probe(8'h88, a);
    check("old_addr", a, 1'b0);
    probe(8'h20, a);
    check("new_addr", a, 1'b1);
    u_host.start();
    u_host.send_byte(hsp_pkg::GC_ADDR, w[1]);
    u_host.send_byte(hsp_pkg::GC_RESET_CMD, w[0]);
    u_host.stop();
    probe(hsp_pkg::SLAVE_ADDR_RST, a);
    check("gc_reset", {w[1:0], a}, 3'b111);
  endtask
  task automatic t_halt_and_wake();
    logic a, b;
    logic [2:0] w;
    fork
      halt_after(255, 1'b0);
      begin
        u_host.tick(20);
        probe(8'h50, a);
      end
    join
    probe(8'h50, b);
    check("foreign_sleep", {a, b, osc_run}, 3'b000);
    probe(8'h88, a);
    check("wake_nack", {a, osc_run}, 2'b01);
    reg_write(8'h88, hsp_pkg::SLEEP_PERIOD_REG, 8'h40, w);
    check("retry_ack", w, 3'b111);
    halt_after(64, 1'b1);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge link_clk);
    @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge link_clk);
    t_reset();
    t_write();
    t_read();
    t_attention();
    t_foreign_and_gc();
    t_halt_and_wake();
    check("bus_hung", hung, 1'b0);
    final_report();
  end
endmodule // tb_host_serial_port_with_sleep
